//--- core/sps_map.vh
// Contract
// [R1] master write to data starts transfer
// [R2] phase 0: clock idle first half-bit
// [R3] phase 1: first half-bit starts active
// [R4] start delay follows rate, not phase
// [R5] fault irq only with error enable
// [R6] no fault flag while detection off
// [R7] master: select low sets fault
// [R8] master fault: disable, empty, reset, release
// [R9] software clears pin directions before enable
// [R10] slave: select rising mid-transfer faults
// [R11] slave phase 0: select low to idle
// [R12] slave phase 1: clock edge to idle
// [R13] fault keeps master select unchanged
// [R14] phase 0 select pulse faults alone
// [R15] slave fault keeps enable; disable aborts
// [R16] deselected slave floats output, ignores clock
// [R17] fault clears by status read, control write
// [R18] slave phase 0 drives msb at select
// [R19] mid-transfer writes wait in buffer
// [R20] select synchronised before use
`ifndef SPS_MAP_VH
`define SPS_MAP_VH
`define SPS_DATA_W     8
`define SPS_BIT_CNT    4'h8
`define SPS_LAST_HALF  4'hF
`define SPS_HALF_BASE  7'h08
`define SPS_BUF_DEPTH  2
`endif

//--- core/sps_sync3.v
`timescale 1ns/1ps
module sps_sync3 #(
    parameter RST_VAL = 1'b1
) (
    input  wire clk_sys, // system clock
    input  wire rst,     // sync reset
    input  wire ce,      // clock enable
    input  wire pinIn,   // asynchronous input
    output reg  levelOut // filtered level
);
    reg s1;
    reg s2;
    reg s3;

    always @(posedge clk_sys) begin
        if (rst) begin
            s1       <= RST_VAL;
            s2       <= RST_VAL;
            s3       <= RST_VAL;
            levelOut <= RST_VAL;
        end else if (ce) begin
            s1 <= pinIn;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                levelOut <= s3;
            end
        end
    end
endmodule // sps_sync3

//--- core/sps_buf2.v
`timescale 1ns/1ps
module sps_buf2 #(
    parameter W = 8
) (
    input  wire         clk_sys,  // system clock
    input  wire         rst,      // sync reset
    input  wire         ce,       // clock enable
    input  wire         inValid,  // write offered
    input  wire [W-1:0] inData,   // write data
    output wire         inReady,  // room for a word
    output wire         outValid, // word waiting
    output wire [W-1:0] outData,  // oldest word
    input  wire         outReady  // consumer takes word
);
    reg [W-1:0] e0_q;
    reg [W-1:0] e1_q;
    reg [1:0]   cnt_q;
    wire        push;
    wire        pop;

    assign inReady  = (cnt_q != 2'h2);
    assign outValid = (cnt_q != 2'h0);
    assign outData  = e0_q;
    assign push     = inValid & inReady;
    assign pop      = outValid & outReady;

    always @(posedge clk_sys) begin
        if (rst) begin
            e0_q  <= {W{1'b0}};
            e1_q  <= {W{1'b0}};
            cnt_q <= 2'h0;
        end else if (ce) begin
            if (pop) begin
                e0_q <= (cnt_q == 2'h2) ? e1_q : inData;
            end else if (push && cnt_q == 2'h0) begin
                e0_q <= inData;
            end
            if (push && ((cnt_q == 2'h1 && !pop) || cnt_q == 2'h2)) begin
                e1_q <= inData;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 2'h1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 2'h1;
            end
        end
    end
endmodule // sps_buf2

//--- core/sps_core.v
`timescale 1ns/1ps
`include "sps_map.vh"
module sps_core (
    input  wire       clk_sys,           // system clock
    input  wire       rst,               // sync reset
    input  wire       ce,                // clock enable
    input  wire       masterSelect,      // 1 master, 0 slave
    input  wire       clockPhase,        // phase select
    input  wire       clockPolarity,     // idle level of clock
    input  wire [1:0] clockRateSelect,   // master rate
    input  wire       faultDetectEnable, // allow mode fault
    input  wire       errorIrqEnable,    // error request gate
    input  wire       rxIrqEnable,       // receive request gate
    input  wire       controlWrite,      // control register write
    input  wire       ctrlModuleEnable,  // enable value written
    input  wire       statusRead,        // status register read
    input  wire       txValid,           // data register write
    input  wire [7:0] txData,            // data written
    output wire       txReady,           // write can be taken
    output reg  [7:0] rxData,            // received byte
    output wire       rxValid,           // receive full
    input  wire       rxReady,           // received byte taken
    output reg        moduleEnable,      // module enable bit
    output reg        transmitEmptyFlag, // transmit empty
    output reg        modeFaultFlag,     // mode fault
    output wire       receiveFullFlag,   // receive full
    output wire       rxErrIrq,          // shared receive/error
    output wire       pinDrive,          // port owns pins
    output wire       busy,              // transfer running
    input  wire       ssIn,              // slave select pin
    input  wire       sclkIn,            // clock pin in
    output reg        sclkOut,           // clock pin out
    output wire       sclkOen_n,         // clock drive, low on
    input  wire       mosiIn,            // master-out pin in
    output wire       mosiOut,           // master-out pin out
    output wire       mosiOen_n,         // master-out drive
    input  wire       misoIn,            // master-in pin in
    output wire       misoOut,           // master-in pin out
    output wire       misoOen_n          // master-in drive
);
    localparam ST_IDLE = 3'h1;
    localparam ST_MRUN = 3'h2;
    localparam ST_SRUN = 3'h4;

    reg  [2:0] state_q;
    reg  [7:0] sh_q;
    reg        inBit_q;
    reg  [3:0] half_q;
    reg  [3:0] bits_q;
    reg  [6:0] div_q;
    reg        ssPrev_q;
    reg        sclkPrev_q;
    reg        clrArm_q;
    reg        rxFull_q;
    wire       ssS;
    wire       sclkS;
    wire       mosiS;
    wire       misoS;
    wire       bufValid;
    wire [7:0] bufData;
    reg        bufPop;
    wire       isMaster;
    wire       isSlave;
    wire       tick;
    wire       ssFall;
    wire       ssRise;
    wire       actEdge;
    wire       idleEdge;
    wire       sampEdge;
    wire       shiftEdge;
    wire       mFault;
    wire       sFault;
    wire       faultNow;
    wire       doneM;
    wire       doneS;
    wire       startM;
    wire       startS;
    wire [7:0] rxWord;

    function [6:0] halfLen;
        input [1:0] rate;
        begin
            halfLen = `SPS_HALF_BASE << rate;
        end
    endfunction

    sps_sync3 #(.RST_VAL(1'b1)) u_ss ( // R20
        .clk_sys  (clk_sys),
        .rst      (rst),
        .ce       (ce),
        .pinIn    (ssIn),
        .levelOut (ssS)
    );

    sps_sync3 #(.RST_VAL(1'b0)) u_sclk (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .ce       (ce),
        .pinIn    (sclkIn),
        .levelOut (sclkS)
    );

    sps_sync3 #(.RST_VAL(1'b0)) u_mosi (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .ce       (ce),
        .pinIn    (mosiIn),
        .levelOut (mosiS)
    );

    sps_sync3 #(.RST_VAL(1'b0)) u_miso (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .ce       (ce),
        .pinIn    (misoIn),
        .levelOut (misoS)
    );

    sps_buf2 #(.W(`SPS_DATA_W)) u_txbuf ( // R19
        .clk_sys  (clk_sys),
        .rst      (rst),
        .ce       (ce),
        .inValid  (txValid),
        .inData   (txData),
        .inReady  (txReady),
        .outValid (bufValid),
        .outData  (bufData),
        .outReady (bufPop)
    );

    // master select only counts while enabled
    assign isMaster = moduleEnable & masterSelect; // R13
    assign isSlave  = moduleEnable & ~masterSelect;
    assign pinDrive = moduleEnable;
    assign busy     = (state_q != ST_IDLE);

    assign tick     = (div_q == halfLen(clockRateSelect) - 7'h01);
    assign ssFall   = ssPrev_q & ~ssS;
    assign ssRise   = ~ssPrev_q & ssS;
    // deselected slave sees no clock edges
    assign actEdge  = ~ssS & (sclkS != sclkPrev_q)
                    & (sclkS != clockPolarity); // R16
    assign idleEdge = ~ssS & (sclkS != sclkPrev_q)
                    & (sclkS == clockPolarity); // R16
    assign sampEdge  = clockPhase ? idleEdge : actEdge;
    assign shiftEdge = clockPhase ? actEdge : idleEdge;

    assign mFault = isMaster & faultDetectEnable & ~ssS; // R7 R6
    assign sFault = isSlave & faultDetectEnable
                  & (state_q == ST_SRUN) & ssRise; // R10 R14 R6
    assign faultNow = mFault | sFault;

    // start waits for the rate divider, phase plays no part
    assign startM = isMaster & (state_q == ST_IDLE)
                  & bufValid & tick & ~mFault; // R1 R4
    assign startS = isSlave & (state_q == ST_IDLE)
                  & (clockPhase ? actEdge : ssFall); // R11 R12
    assign doneM  = (state_q == ST_MRUN) & tick
                  & (half_q == `SPS_LAST_HALF);
    assign doneS  = (state_q == ST_SRUN) & ~ssS
                  & (clockPhase
                     ? (sampEdge && bits_q == `SPS_BIT_CNT - 4'h1)
                     : (shiftEdge && bits_q == `SPS_BIT_CNT)); // R11 R12
    assign rxWord = {sh_q[6:0], clockPhase & doneS
                                ? mosiS : inBit_q};

    always @* begin
        bufPop = startM | (startS & bufValid);
    end

    assign rxValid         = rxFull_q;
    assign receiveFullFlag = rxFull_q;
    assign rxErrIrq = (modeFaultFlag & errorIrqEnable)
                    | (rxFull_q & rxIrqEnable); // R5

    assign mosiOut   = sh_q[7];
    assign mosiOen_n = ~isMaster;
    assign misoOut   = sh_q[7]; // R18
    assign misoOen_n = ~(isSlave & ~ssS); // R16
    assign sclkOen_n = ~isMaster;

    always @(posedge clk_sys) begin
        if (rst) begin
            ssPrev_q   <= 1'b1;
            sclkPrev_q <= 1'b0;
            div_q      <= 7'h00;
        end else if (ce) begin
            ssPrev_q   <= ssS;
            sclkPrev_q <= sclkS;
            if (tick || !isMaster) begin
                div_q <= 7'h00;
            end else begin
                div_q <= div_q + 7'h01;
            end
        end
    end

    // transfer engine
    always @(posedge clk_sys) begin
        if (rst) begin
            state_q <= ST_IDLE;
            sh_q    <= 8'h00;
            inBit_q <= 1'b0;
            half_q  <= 4'h0;
            bits_q  <= 4'h0;
            sclkOut <= 1'b0;
        end else if (ce) begin
            case (state_q)
                ST_IDLE: begin
                    sclkOut <= clockPolarity;
                    half_q  <= 4'h0;
                    bits_q  <= 4'h0;
                    if (startM) begin
                        state_q <= ST_MRUN;
                        sh_q    <= bufData;
                        // phase 1 opens on the active level
                        sclkOut <= clockPolarity ^ clockPhase; // R2 R3
                    end else if (startS) begin
                        state_q <= ST_SRUN;
                        if (bufValid) begin
                            sh_q <= bufData; // R18
                        end
                    end
                end
                ST_MRUN: begin
                    if (mFault || !isMaster) begin
                        state_q <= ST_IDLE; // R8
                        half_q  <= 4'h0;
                        sclkOut <= clockPolarity;
                    end else if (tick) begin
                        half_q <= half_q + 4'h1;
                        if (!half_q[0]) begin
                            inBit_q <= misoS;
                        end else if (doneM) begin
                            state_q <= ST_IDLE;
                        end else begin
                            sh_q <= {sh_q[6:0], inBit_q};
                        end
                        if (doneM) begin
                            sclkOut <= clockPolarity;
                        end else begin
                            sclkOut <= clockPolarity ^ clockPhase
                                     ^ ~half_q[0]; // R2 R3
                        end
                    end
                end
                ST_SRUN: begin
                    if (!isSlave || sFault) begin
                        state_q <= ST_IDLE; // R15 R10
                    end else if (doneS) begin
                        state_q <= ST_IDLE;
                    end else if (sampEdge) begin
                        inBit_q <= mosiS;
                        bits_q  <= bits_q + 4'h1;
                    end else if (shiftEdge) begin
                        sh_q <= {sh_q[6:0], inBit_q};
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // enable, flags and receive holding register
    always @(posedge clk_sys) begin
        if (rst) begin
            moduleEnable      <= 1'b0;
            transmitEmptyFlag <= 1'b1;
            modeFaultFlag     <= 1'b0;
            clrArm_q          <= 1'b0;
            rxFull_q          <= 1'b0;
            rxData            <= 8'h00;
        end else if (ce) begin
            if (mFault) begin
                moduleEnable <= 1'b0; // R8
            end else if (controlWrite) begin
                moduleEnable <= ctrlModuleEnable; // R9 R15
            end
            if (mFault || bufPop) begin
                transmitEmptyFlag <= 1'b1; // R8
            end else if (txValid && txReady) begin
                transmitEmptyFlag <= 1'b0;
            end
            // clear needs read then write with no fault between
            if (faultNow) begin
                modeFaultFlag <= 1'b1; // R7 R10 R13
                clrArm_q      <= 1'b0; // R17
            end else if (controlWrite && clrArm_q) begin
                modeFaultFlag <= 1'b0; // R17
                clrArm_q      <= 1'b0;
            end else if (statusRead && modeFaultFlag) begin
                clrArm_q <= 1'b1; // R17
            end
            // no overrun handling: a full holder keeps its byte
            if (doneM || doneS) begin
                if (!rxFull_q || rxReady) begin
                    rxData <= doneM ? {sh_q[6:0], inBit_q} : rxWord;
                end
                rxFull_q <= 1'b1;
            end else if (rxReady) begin
                rxFull_q <= 1'b0;
            end
        end
    end
endmodule // sps_core

//--- tb/sps_core_props.sv
`timescale 1ns/1ps
module sps_core_props (
    input wire clk_sys,           // clock
    input wire rst,               // reset
    input wire masterSelect,      // mode
    input wire clockPhase,        // phase
    input wire clockPolarity,     // idle
    input wire faultDetectEnable, // gate
    input wire errorIrqEnable,    // gate
    input wire rxIrqEnable,       // gate
    input wire controlWrite,      // write
    input wire txValid,           // write
    input wire txReady,           // room
    input wire moduleEnable,      // enable
    input wire transmitEmptyFlag, // empty
    input wire modeFaultFlag,     // fault
    input wire receiveFullFlag,   // full
    input wire rxErrIrq,          // request
    input wire pinDrive,          // owner
    input wire busy,              // running
    input wire ssIn,              // select
    input wire sclkOut,           // clock
    input wire sclkOen_n,         // drive
    input wire misoOen_n          // drive
);
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    a_irq_gate: assert property (
        rxErrIrq == (modeFaultFlag && errorIrqEnable
        || receiveFullFlag && rxIrqEnable)) else $error("request wrong");
    a_fault_gated: assert property ($rose(modeFaultFlag)
        |-> $past(faultDetectEnable)) else $error("fault while gated");
    a_master_fault: assert property ($rose(modeFaultFlag) && masterSelect
        |-> !moduleEnable && transmitEmptyFlag && !busy && !pinDrive)
        else $error("master fault state");
    a_slave_fault: assert property ($rose(modeFaultFlag) && !masterSelect
        |-> moduleEnable) else $error("slave fault disabled");
    a_pin_release: assert property (pinDrive == moduleEnable)
        else $error("pin owner");
    a_sclk_start: assert property ($rose(busy) && masterSelect
        |-> sclkOut == (clockPolarity ^ clockPhase)) else $error("first level");
    a_miso_float: assert property (ssIn [*5] |=> misoOen_n)
        else $error("miso driven");
    a_master_ss: assert property ((masterSelect && moduleEnable
        && faultDetectEnable && !ssIn) [*6] |-> modeFaultFlag)
        else $error("select low ignored");
    a_clear_path: assert property ($fell(modeFaultFlag)
        |-> $past(controlWrite)) else $error("fault lost");
    a_clk_drive: assert property (!sclkOen_n
        |-> moduleEnable && masterSelect) else $error("clock driven");
    a_tx_taken: assert property (txValid && txReady
        |=> !transmitEmptyFlag) else $error("write not seen");
endmodule // sps_core_props

bind sps_core sps_core_props sps_core_props_inst (.*);

//--- tb/sps_peer.sv
`timescale 1ns/1ps
module sps_peer (
    input  wire sclkOut,       // device clock
    input  wire mosiOut,       // device data
    input  wire misoIn,        // miso line
    input  wire clockPhase,    // phase
    input  wire clockPolarity, // idle
    output reg  ssPin,         // select
    output reg  sclkPin,       // clock
    output reg  mosiPin,       // data
    output wire misoReply      // reply bit
);
    reg [7:0] rep;
    reg [7:0] cap;
    assign misoReply = rep[7];
    initial begin
        {ssPin, sclkPin, mosiPin} = 3'h4;
        {rep, cap} = 16'h0000;
    end
    task load(input [7:0] b);
        rep = b;
    endtask
    // slave side: sample and move on at the sampling edge
    always @(sclkOut)
        if (sclkOut ^ clockPolarity ^ clockPhase) begin
            cap = {cap[6:0], mosiOut};
            rep = {rep[6:0], ~rep[0]};
        end
    // master side, clock stands at idle between frames
    task frame(input [7:0] tx, input integer nb, output [7:0] rx);
        integer i;
        begin
            rx = 8'h00;
            sclkPin = clockPolarity;
            #62.5;
            ssPin = 1'b0;
            #62.5;
            for (i = 7; i >= 8 - nb; i = i - 1) begin
                mosiPin = tx[i];
                sclkPin = clockPhase ? ~clockPolarity : clockPolarity;
                #62.5;
                sclkPin = ~sclkPin;
                rx[i] = misoIn;
                #62.5;
                sclkPin = clockPolarity;
            end
            #62.5;
            ssPin = 1'b1;
            mosiPin = ~mosiPin;
        end
    endtask
endmodule // sps_peer

//--- tb/sps_core_test.sv
`timescale 1ns/1ps
module sps_core_test;
    reg        clk_sys, rst, ce, masterSelect, clockPhase, clockPolarity;
    reg        faultDetectEnable, errorIrqEnable, rxIrqEnable, controlWrite;
    reg        ctrlModuleEnable, statusRead, txValid, rxReady, tgl;
    reg  [1:0] clockRateSelect;
    reg  [7:0] txData, got;
    wire [7:0] rxData;
    wire       txReady, rxValid, moduleEnable, transmitEmptyFlag;
    wire       modeFaultFlag, receiveFullFlag, rxErrIrq, pinDrive, busy;
    wire       sclkOut, sclkOen_n, mosiOut, mosiOen_n, misoOut, misoOen_n;
    wire       ssIn, sclkIn, mosiIn, misoIn, sclkPin, mosiPin, misoReply;
    integer    err_count, cmp_count, n, k;

    sps_core sps_core_inst (.*);
    sps_peer sps_peer_inst (.sclkOut(sclkOut), .mosiOut(mosiOut),
        .misoIn(misoIn), .clockPhase(clockPhase), .ssPin(ssIn),
        .clockPolarity(clockPolarity), .sclkPin(sclkPin),
        .mosiPin(mosiPin), .misoReply(misoReply));
    assign sclkIn = sclkOen_n ? sclkPin : sclkOut;
    assign mosiIn = mosiOen_n ? mosiPin : mosiOut;
    assign misoIn = !misoOen_n ? misoOut : masterSelect ? misoReply : tgl;

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(negedge clk_sys) tgl <= ~tgl;
    task cyc(input integer c);
        repeat (c) @(negedge clk_sys);
    endtask
    task chk(input string nm, input [7:0] e, input [7:0] s);
        begin
            cmp_count = cmp_count + 1;
            if (s !== e) begin
                err_count = err_count + 1;
                $display("wrong value %s expected %h seen %h", nm, e, s);
            end
        end
    endtask
    task ctl(input en);
        begin
            ctrlModuleEnable = en;
            {controlWrite, rxReady} = 2'h3;
            cyc(1);
            {controlWrite, rxReady} = 2'h0;
            cyc(1);
        end
    endtask
    task wr(input [7:0] b);
        begin
            txData = b;
            txValid = 1'b1;
            cyc(1);
            txValid = 1'b0;
        end
    endtask
    task wt(input sel, input v);
        begin
            n = 0;
            while ((sel ? modeFaultFlag : busy) !== v && n < 3000) begin
                cyc(1);
                n = n + 1;
            end
            if (n >= 3000) begin
                err_count = err_count + 1;
                $display("wrong value wait limit expected %h seen %h", v, n);
            end
        end
    endtask
    task t_master(input [1:0] r, input ph);
        begin
            {masterSelect, faultDetectEnable, rxIrqEnable} = 3'h7;
            {clockRateSelect, clockPhase, clockPolarity} = {r, ph, r[0]};
            ctl(1'b1);
            chk("master drives", 8'h00, {mosiOen_n, sclkOen_n});
            sps_peer_inst.load(8'hC3 ^ r);
            wr(8'hA5 ^ r);
            wt(1'b0, 1'b1);
            chk("start delay", 8'h01, n >= 1 && n <= (8 << r) + 1);
            wt(1'b0, 1'b0);
            cyc(1);
            chk("master rx", 8'hC3 ^ r, rxData);
            chk("peer rx", 8'hA5 ^ r, sps_peer_inst.cap);
            chk("rx request", 8'h01, rxErrIrq);
            chk("full flags", 8'h03, {rxValid, receiveFullFlag});
            ctl(1'b0);
            $display("master transfer test done");
        end
    endtask
    task t_slave(input ph, input [7:0] a, input [7:0] b);
        begin
            {masterSelect, clockPhase, clockPolarity} = {1'b0, ph, ph};
            ctl(1'b1);
            txData = a;
            txValid = 1'b1;
            cyc(1);
            txData = b;
            cyc(1);
            chk("ready when full", 8'h00, txReady);
            txData = 8'hFF;
            cyc(1);
            txValid = 1'b0;
            sps_peer_inst.frame(8'h5A, 8, got);
            cyc(1);
            chk("slave tx first", a, got);
            chk("slave rx", 8'h5A, rxData);
            ctl(1'b1);
            sps_peer_inst.frame(8'h3C, 8, got);
            cyc(1);
            chk("slave tx second", b, got);
            chk("fault and ready", 8'h01, {modeFaultFlag, txReady});
            ctl(1'b0);
            $display("slave transfer test done");
        end
    endtask
    task t_sfault(input ph);
        begin
            {masterSelect, clockPhase} = {1'b0, ph};
            {errorIrqEnable, rxIrqEnable} = 2'h2;
            ctl(1'b1);
            sps_peer_inst.frame(8'h00, 0, got);
            cyc(6);
            chk("select pulse fault", !ph, modeFaultFlag);
            chk("slave keeps enable", 8'h01, moduleEnable);
            chk("error request", !ph, rxErrIrq);
            ctl(1'b1);
            chk("write alone keeps", !ph, modeFaultFlag);
            {statusRead, errorIrqEnable} = 2'h2;
            cyc(1);
            statusRead = 1'b0;
            ctl(1'b0);
            chk("fault cleared", 8'h00, modeFaultFlag);
            $display("slave fault test done");
        end
    endtask
    task t_mfault;
        begin
            {masterSelect, errorIrqEnable, clockRateSelect} = 4'hF;
            sps_peer_inst.ssPin = 1'b0;
            wr(8'h77);
            cyc(5);
            chk("disabled no fault", 8'h00, modeFaultFlag);
            ctl(1'b1);
            wt(1'b1, 1'b1);
            chk("master fault", 8'h07, {moduleEnable, pinDrive,
                transmitEmptyFlag, rxErrIrq, sclkOen_n});
            sps_peer_inst.ssPin = 1'b1;
            cyc(5);
            statusRead = 1'b1;
            cyc(1);
            statusRead = 1'b0;
            ctl(1'b0);
            chk("master fault cleared", 8'h00, modeFaultFlag);
            faultDetectEnable = 1'b0;
            ctl(1'b1);
            sps_peer_inst.ssPin = 1'b0;
            cyc(10);
            chk("detect off", 8'h01, {modeFaultFlag, moduleEnable});
            sps_peer_inst.ssPin = 1'b1;
            ctl(1'b0);
            $display("master fault test done");
        end
    endtask
    task finish_test;
        begin
            $display("compared %0d, wrong %0d", cmp_count, err_count);
            if (err_count == 0 && cmp_count > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask
    initial begin
        #800000;
        err_count = err_count + 1;
        finish_test;
    end
    initial begin
        {rst, ce, tgl, masterSelect, clockPhase, clockPolarity} = 6'h30;
        {faultDetectEnable, errorIrqEnable, rxIrqEnable} = 3'h0;
        {controlWrite, ctrlModuleEnable, statusRead} = 3'h0;
        {txValid, rxReady, clockRateSelect, txData, got} = 20'h00000;
        {err_count, cmp_count} = 64'h0;
        cyc(6);
        rst = 1'b0;
        cyc(1);
        chk("reset values", 8'h4E, {moduleEnable, transmitEmptyFlag,
            modeFaultFlag, rxValid, txReady, sclkOen_n, misoOen_n, rxErrIrq});
        $display("reset test done");
        for (k = 0; k < 8; k = k + 1)
            t_master(k[2:1], k[0]);
        t_slave(1'b0, 8'h81, 8'h42);
        t_slave(1'b1, 8'h24, 8'hE7);
        t_sfault(1'b0);
        t_sfault(1'b1);
        t_mfault;
        finish_test;
    end
endmodule // sps_core_test
